// >>> logic/drs_pkg.sv
// package: register map, field layout, timing and carrier types
package drs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INH_LO   = 8'h1a;
  localparam logic [7:0] OFS_INH_HI   = 8'h1b;
  localparam logic [7:0] OFS_TIMING   = 8'h1c;
  localparam logic [7:0] OFS_CTL_A    = 8'h1d;
  localparam logic [7:0] OFS_CTL_B    = 8'h1e;
  localparam logic [7:0] OFS_MODE     = 8'h1f;
  localparam logic [7:0] OFS_REFSEL   = 8'h20;
  localparam logic [7:0] OFS_FMASK    = 8'h21;
  localparam logic [7:0] OFS_WTR      = 8'h22;
  localparam logic [7:0] OFS_REV      = 8'h23;
  localparam logic [7:0] OFS_RANK0    = 8'h24;
  localparam logic [7:0] OFS_RANK3    = 8'h27;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  // reset values
  localparam logic [7:0] RST_INH      = 8'hff;
  localparam logic [7:0] RST_TIMING   = 8'h15;
  localparam logic [7:0] RST_CTL_A    = 8'h7b;
  localparam logic [7:0] RST_CTL_B    = 8'hc4;
  localparam logic [7:0] RST_FMASK    = 8'h3c;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [31:0] RST_RANK    = 32'h7654_3210;
  // field positions
  localparam int CTLA_HS    = 0;
  localparam int CTLA_BW_LO = 1;
  localparam int CTLA_SL_LO = 4;
  localparam int CTLB_REV   = 0;
  localparam int CTLB_OFS   = 1;
  localparam int TIM_QUAL   = 4;
  localparam int FM_HOLD    = 4;
  // failure type bits inside a mask nibble
  localparam int F_CYCLE   = 0;
  localparam int F_COARSE  = 1;
  localparam int F_GST     = 2;
  localparam int F_PRECISE = 3;
  localparam logic [3:0] RANK_OFF   = 4'hf;
  localparam logic [2:0] BW_14      = 3'b011;
  localparam logic [2:0] BW_28      = 3'b100;
  localparam logic [2:0] BW_890     = 3'b101;
  localparam logic [1:0] MD_MANUAL  = 2'b00;
  localparam logic [1:0] MD_HOLD    = 2'b01;
  localparam logic [1:0] MD_FREE    = 2'b10;
  localparam logic [1:0] MD_AUTO    = 2'b11;
  // time base: clock period, soak tick and minute
  localparam int CLK_NS      = 10;
  localparam int TICK_US     = 500;
  localparam int MINUTE_MS   = 60_000;
  localparam int TICK_CYC    = TICK_US * 1000 / CLK_NS;
  localparam int MINUTE_TICK = MINUTE_MS * 1000 / TICK_US;
  localparam int STRAP_WAIT  = 2;

  typedef enum logic [1:0] {LS_FREE, LS_TRACK, LS_HOLD} drs_lstate_t;
  typedef enum logic [1:0] {BWE_14, BWE_28, BWE_56, BWE_890} drs_bw_t;

  typedef struct packed {
    logic [3:0] disq_code;
    logic [1:0] qual_code;
    logic [3:0] sw_mask;
    logic [3:0] hold_mask;
    logic [3:0] wtr_min;
  } drs_qual_cfg_t;

  typedef struct packed {
    logic gst_fail;
    logic sw_fail;
    logic hold_fail;
    logic avail;
  } drs_ref_stat_t;

  typedef struct packed {
    drs_lstate_t state;
    logic [2:0]  ref_idx;
    logic        switch_evt;
    logic        realign;
    drs_bw_t     bandwidth;
    logic [1:0]  slew_code;
    logic        offset_en;
  } drs_loop_out_t;

  // disqualify time in soak ticks; code 0 means act at once
  function automatic logic [16:0] disq_ticks(input logic [3:0] code);
    case (code)
      4'h0: disq_ticks = 17'd0;
      4'h1: disq_ticks = 17'd1;
      4'h2: disq_ticks = 17'd2;
      4'h3: disq_ticks = 17'd10;
      4'h4: disq_ticks = 17'd20;
      4'h5: disq_ticks = 17'd100;
      4'h6: disq_ticks = 17'd1000;
      4'h7: disq_ticks = 17'd1000;
      4'h8: disq_ticks = 17'd2000;
      4'h9: disq_ticks = 17'd4000;
      4'ha: disq_ticks = 17'd5000;
      4'hb: disq_ticks = 17'd8000;
      4'hc: disq_ticks = 17'd16000;
      4'hd: disq_ticks = 17'd32000;
      4'he: disq_ticks = 17'd64000;
      default: disq_ticks = 17'd128000;
    endcase
  endfunction : disq_ticks
endpackage : drs_pkg

// >>> logic/drs_ref_qual.sv
// one reference: guard soak timer, failure masking, restore_delay_minutes
`timescale 1ns/100ps
`default_nettype none
module drs_ref_qual (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   tick,
  input  wire logic                   tick_min,
  input  wire logic                   cycle_fail,
  input  wire logic                   coarse_fail,
  input  wire logic                   precise_fail,
  input  wire logic [1:0]             inhibit,
  input  wire drs_pkg::drs_qual_cfg_t cfg,
  output drs_pkg::drs_ref_stat_t      stat
);
  typedef struct packed {
    logic [22:0] cnt;
    logic        gst;
    logic [3:0]  wtr_cnt;
    logic        restored;
  } drs_qual_st_t;

  drs_qual_st_t st_r, st_nxt;
  logic         soak_in;
  logic [22:0]  disq;
  logic [22:0]  qual;
  logic [3:0]   fvec;
  logic         bad;

  always_comb begin
    soak_in = (cycle_fail & ~inhibit[0]) | (coarse_fail & ~inhibit[1]);
    disq    = {6'd0, drs_pkg::disq_ticks(cfg.disq_code)};
    case (cfg.qual_code)
      2'b00:   qual = disq << 1;
      2'b01:   qual = disq << 2;
      2'b10:   qual = disq << 4;
      default: qual = disq << 5;
    endcase
    fvec = {precise_fail, st_r.gst, coarse_fail, cycle_fail};
    bad  = |(fvec & (cfg.sw_mask | cfg.hold_mask));
    st_nxt = st_r;
    if (!st_r.gst) begin
      if (soak_in && (disq == 23'd0 || (tick && st_r.cnt + 23'd1 >= disq)))
      begin
        st_nxt.gst = 1'b1;
        st_nxt.cnt = 23'd0;
      end else if (soak_in && tick) begin
        st_nxt.cnt = st_r.cnt + 23'd1;
      end else if (!soak_in && tick && st_r.cnt != 23'd0) begin
        // leaky count: each fault-free tick takes one tick off the soak count
        st_nxt.cnt = st_r.cnt - 23'd1;
      end
    end else if (soak_in) begin
      st_nxt.cnt = 23'd0;
    end else if (qual == 23'd0 || (tick && st_r.cnt + 23'd1 >= qual)) begin
      st_nxt.gst = 1'b0;
      st_nxt.cnt = 23'd0;
    end else if (tick) begin
      st_nxt.cnt = st_r.cnt + 23'd1;
    end
    if (bad) begin
      st_nxt.wtr_cnt  = 4'd0;
      st_nxt.restored = 1'b0;
    end else if (!st_r.restored) begin
      if (st_r.wtr_cnt >= cfg.wtr_min) begin
        st_nxt.restored = 1'b1;
      end else if (tick_min) begin
        st_nxt.wtr_cnt = st_r.wtr_cnt + 4'd1;
      end
    end
    stat.gst_fail  = st_r.gst;
    stat.sw_fail   = |(fvec & cfg.sw_mask);
    stat.hold_fail = |(fvec & cfg.hold_mask);
    stat.avail     = ~bad & st_r.restored;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{cnt: 23'd0, gst: 1'b0, wtr_cnt: 4'd0, restored: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : drs_ref_qual
`default_nettype wire

// >>> logic/drs_rank_pick.sv
// picks the best-ranked candidate reference
`timescale 1ns/100ps
`default_nettype none
module drs_rank_pick (
  input  wire logic [7:0]      cand,
  input  wire logic [7:0][3:0] rank,
  output logic                 found,
  output logic [2:0]           idx,
  output logic [3:0]           best
);
  always_comb begin
    found = 1'b0;
    idx   = 3'd0;
    best  = drs_pkg::RANK_OFF;
    for (int i = 0; i < 8; i++) begin
      // strict compare keeps the lower index on a tie
      if (cand[i] && rank[i] != drs_pkg::RANK_OFF &&
          (!found || rank[i] < best)) begin
        found = 1'b1;
        idx   = 3'(i);
        best  = rank[i];
      end
    end
  end
endmodule : drs_rank_pick
`default_nettype wire

// >>> logic/drs_loop_ctrl.sv
// transmit loop reference selection and control registers
//
// Overview of operation
// - two inhibit bits per reference block single-cycle and coarse to soak timer
// - four-bit code sets soak disqualify time, 0 minimum, up to 64 s
// - requalify time is 2, 4, 16 or 32 times disqualify time
// - hitless bit 0 builds out phase, 1 realigns to new reference
// - hitless bit powers up 0 when strap pin high, else 1
// - bandwidth 011 14 Hz, 100 28 Hz, 101 890 Hz, low-rate limits
// - slew limit 885 ns/s, 7.5 us/s, 61 us/s or unlimited
// - global revertive bit, 0 non-revertive by default
// - free-run offset enable bit, 0 by default
// - mode 00 tracks chosen reference, holdover if it fails
// - mode 01 stays in holdover, mode 10 stays in free-run
// - mode 11 picks best qualified reference, next on failure, else holdover
// - mode field resets from the two mode strap pins
// - reference select read-only in auto, writable in manual normal
// - low mask nibble enables failure types for switching
// - high mask nibble enables failure types for holdover entry; here these also switch to an alternate when one is found
// - failed reference returns after fault-free restore_delay_minutes minutes
// - one revertive enable bit per reference
// - four-bit rank per reference, 0 best, 1111 excluded
// - status flags for holdover, lock and current reference failure
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module drs_loop_ctrl #(
  parameter int TICK_CYC    = drs_pkg::TICK_CYC,
  parameter int MINUTE_TICK = drs_pkg::MINUTE_TICK
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              hitless_strap,
  input  wire logic [1:0]        mode_strap,
  input  wire logic [7:0]        mon_cycle_fail,
  input  wire logic [7:0]        mon_coarse_fail,
  input  wire logic [7:0]        mon_precise_fail,
  input  wire logic [7:0]        ref_is_2k,
  input  wire logic [7:0]        ref_is_8k,
  input  wire logic              loop_locked,
  output drs_pkg::drs_loop_out_t loop_out
);
  typedef struct packed {
    logic                  hs_s1;
    logic                  hs_s2;
    logic [1:0]            md_s1;
    logic [1:0]            md_s2;
    logic [1:0]            strap_cnt;
    logic                  strap_done;
    logic [15:0]           inhibit;
    logic [7:0]            timing;
    logic [7:0]            ctl_a;
    logic [7:0]            ctl_b;
    logic [1:0]            mode;
    logic [3:0]            refsel;
    logic [7:0]            fmask;
    logic [3:0]            wtr;
    logic [7:0]            rev;
    logic [7:0][3:0]       rank;
    logic [19:0]           tick_cnt;
    logic [19:0]           min_cnt;
    logic                  tick;
    logic                  tick_min;
    drs_pkg::drs_lstate_t  lstate;
    logic [2:0]            active;
    logic                  hold_flag;
    logic [7:0]            rdata;
    drs_pkg::drs_loop_out_t out;
  } drs_top_st_t;

  drs_top_st_t             st_r, st_nxt;
  drs_pkg::drs_qual_cfg_t  qcfg;
  drs_pkg::drs_ref_stat_t  rstat [8];
  logic [7:0]              avail;
  logic [7:0]              sw_fail;
  logic [7:0]              hold_fail;
  logic [7:0]              cand_all;
  logic [7:0]              cand_other;

  logic                    best_found;
  logic [2:0]              best_idx;
  logic [3:0]              best_rank;
  logic                    alt_found;
  logic [2:0]              alt_idx;
  logic [3:0]              alt_rank;

  logic                    cur_bad;
  logic                    cur_fail_flag;

  always_comb begin
    qcfg.disq_code = st_r.timing[3:0];
    qcfg.qual_code = st_r.timing[drs_pkg::TIM_QUAL +: 2];
    qcfg.sw_mask   = st_r.fmask[3:0];
    qcfg.hold_mask = st_r.fmask[drs_pkg::FM_HOLD +: 4];
    qcfg.wtr_min   = st_r.wtr;
  end

  for (genvar g = 0; g < 8; g++) begin : g_ref
    drs_ref_qual u_qual (
      .clk      (clk),
      .arst_n   (arst_n),
      .tick     (st_r.tick),
      .tick_min (st_r.tick_min),
      .cycle_fail   (mon_cycle_fail[g]),
      .coarse_fail  (mon_coarse_fail[g]),
      .precise_fail (mon_precise_fail[g]),
      .inhibit  (st_r.inhibit[2*g +: 2]),
      .cfg      (qcfg),
      .stat     (rstat[g])
    );
    assign avail[g]     = rstat[g].avail;
    assign sw_fail[g]   = rstat[g].sw_fail;
    assign hold_fail[g] = rstat[g].hold_fail;
  end

  always_comb begin
    cand_all   = avail;
    // alternates exclude the reference now in use
    cand_other = avail & ~(8'h01 << st_r.active);
  end

  drs_rank_pick u_pick_all (
    .cand  (cand_all),
    .rank  (st_r.rank),
    .found (best_found),
    .idx   (best_idx),
    .best  (best_rank)
  );

  drs_rank_pick u_pick_alt (
    .cand  (cand_other),
    .rank  (st_r.rank),
    .found (alt_found),
    .idx   (alt_idx),
    .best  (alt_rank)
  );

  // effective bandwidth, capped for low-rate references
  function automatic drs_pkg::drs_bw_t eff_bw(input logic [2:0] code,
                                              input logic       is_2k,
                                              input logic       is_8k);
    case (code)
      drs_pkg::BW_28:  eff_bw = is_2k ? drs_pkg::BWE_14 : drs_pkg::BWE_28;
      drs_pkg::BW_890: eff_bw = is_2k ? drs_pkg::BWE_14 :
                                (is_8k ? drs_pkg::BWE_56 : drs_pkg::BWE_890);
      default:         eff_bw = drs_pkg::BWE_14;
    endcase
  endfunction : eff_bw

  // rank byte address to the slot of its even reference
  function automatic logic [2:0] rank_slot(input logic [7:0] addr);
    logic [7:0] ofs;
    ofs       = addr - drs_pkg::OFS_RANK0;
    rank_slot = {ofs[1:0], 1'b0};
  endfunction : rank_slot

  // true for the four rank bytes
  function automatic logic is_rank(input logic [7:0] addr);
    is_rank = addr >= drs_pkg::OFS_RANK0 && addr <= drs_pkg::OFS_RANK3;
  endfunction : is_rank

  always_comb begin
    st_nxt = st_r;
    cur_bad = sw_fail[st_r.active] | hold_fail[st_r.active];
    cur_fail_flag = cur_bad;

    // strap pins are asynchronous: two flops before use
    st_nxt.hs_s1 = hitless_strap;
    st_nxt.hs_s2 = st_r.hs_s1;
    st_nxt.md_s1 = mode_strap;
    st_nxt.md_s2 = st_r.md_s1;
    if (!st_r.strap_done) begin
      if (st_r.strap_cnt == 2'(drs_pkg::STRAP_WAIT)) begin
        st_nxt.strap_done = 1'b1;
        st_nxt.ctl_a[drs_pkg::CTLA_HS] = ~st_r.hs_s2;
        st_nxt.mode = st_r.md_s2;
      end else begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'd1;
      end
    end

    // soak tick and minute tick
    // one shared tick keeps every soak timer in step
    st_nxt.tick     = 1'b0;
    st_nxt.tick_min = 1'b0;
    if (st_r.tick_cnt == 20'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 20'd0;
      st_nxt.tick     = 1'b1;
      if (st_r.min_cnt == 20'(MINUTE_TICK - 1)) begin
        st_nxt.min_cnt  = 20'd0;
        st_nxt.tick_min = 1'b1;
      end else begin
        st_nxt.min_cnt = st_r.min_cnt + 20'd1;
      end
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 20'd1;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        drs_pkg::OFS_INH_LO: st_nxt.inhibit[7:0]  = reg_wdata;
        drs_pkg::OFS_INH_HI: st_nxt.inhibit[15:8] = reg_wdata;
        drs_pkg::OFS_TIMING: st_nxt.timing = reg_wdata;
        drs_pkg::OFS_CTL_A:  st_nxt.ctl_a  = reg_wdata;
        drs_pkg::OFS_CTL_B:  st_nxt.ctl_b  = reg_wdata;
        drs_pkg::OFS_MODE:   st_nxt.mode   = reg_wdata[1:0];
        drs_pkg::OFS_REFSEL: begin
          // selection only writable in manual normal mode
          if (st_r.mode == drs_pkg::MD_MANUAL) begin
            st_nxt.refsel = reg_wdata[3:0];
          end
        end
        drs_pkg::OFS_FMASK:  st_nxt.fmask = reg_wdata;
        drs_pkg::OFS_WTR:    st_nxt.wtr   = reg_wdata[3:0];
        drs_pkg::OFS_REV:    st_nxt.rev   = reg_wdata;
        default: begin
          if (is_rank(reg_addr)) begin
            st_nxt.rank[rank_slot(reg_addr)]        = reg_wdata[3:0];
            st_nxt.rank[rank_slot(reg_addr) + 3'd1] = reg_wdata[7:4];
          end
        end
      endcase
    end

    // reference selection per mode
    st_nxt.out.switch_evt = 1'b0;
    case (st_r.mode)
      drs_pkg::MD_MANUAL: begin
        if (!st_r.refsel[3] && avail[st_r.refsel[2:0]]) begin
          st_nxt.lstate = drs_pkg::LS_TRACK;
          st_nxt.active = st_r.refsel[2:0];
        end else if (st_r.lstate == drs_pkg::LS_TRACK) begin
          st_nxt.lstate = drs_pkg::LS_HOLD;
        end
        // a reserved select code counts as failed
        cur_fail_flag = st_r.refsel[3] | sw_fail[st_r.refsel[2:0]] |
                        hold_fail[st_r.refsel[2:0]];
      end
      drs_pkg::MD_HOLD: st_nxt.lstate = drs_pkg::LS_HOLD;
      drs_pkg::MD_FREE: st_nxt.lstate = drs_pkg::LS_FREE;
      drs_pkg::MD_AUTO: begin
        if (st_r.lstate == drs_pkg::LS_TRACK && !cur_bad) begin
          // revert only to a strictly better, restored reference
          if (best_found && best_idx != st_r.active &&
              best_rank < st_r.rank[st_r.active] &&
              st_r.ctl_b[drs_pkg::CTLB_REV] && st_r.rev[best_idx]) begin
            st_nxt.active = best_idx;
          end
        end else if (st_r.lstate == drs_pkg::LS_TRACK) begin
          if (alt_found) begin
            st_nxt.active = alt_idx;
          end else begin
            st_nxt.lstate = drs_pkg::LS_HOLD;
          end
        end else if (best_found) begin
          st_nxt.lstate = drs_pkg::LS_TRACK;
          st_nxt.active = best_idx;
        end
        st_nxt.refsel = {1'b0, st_nxt.active};
      end
      default: st_nxt.lstate = drs_pkg::LS_FREE;
    endcase

    // pulse once for every new tracking target
    if (st_nxt.lstate == drs_pkg::LS_TRACK &&
        (st_r.lstate != drs_pkg::LS_TRACK || st_nxt.active != st_r.active))
    begin
      st_nxt.out.switch_evt = 1'b1;
    end
    st_nxt.hold_flag = (st_nxt.lstate == drs_pkg::LS_HOLD);

    // loop outputs, registered
    st_nxt.out.state     = st_nxt.lstate;
    st_nxt.out.ref_idx   = st_nxt.active;
    st_nxt.out.realign   = st_nxt.ctl_a[drs_pkg::CTLA_HS];
    st_nxt.out.bandwidth = eff_bw(st_nxt.ctl_a[drs_pkg::CTLA_BW_LO +: 3],
                                  ref_is_2k[st_nxt.active],
                                  ref_is_8k[st_nxt.active]);
    st_nxt.out.slew_code = st_nxt.ctl_a[drs_pkg::CTLA_SL_LO +: 2];
    st_nxt.out.offset_en = st_nxt.ctl_b[drs_pkg::CTLB_OFS];

    // read data stands one cycle only
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        drs_pkg::OFS_INH_LO: st_nxt.rdata = st_r.inhibit[7:0];
        drs_pkg::OFS_INH_HI: st_nxt.rdata = st_r.inhibit[15:8];
        drs_pkg::OFS_TIMING: st_nxt.rdata = st_r.timing;
        drs_pkg::OFS_CTL_A:  st_nxt.rdata = st_r.ctl_a;
        drs_pkg::OFS_CTL_B:  st_nxt.rdata = st_r.ctl_b;
        drs_pkg::OFS_MODE:   st_nxt.rdata = {6'd0, st_r.mode};
        drs_pkg::OFS_REFSEL: st_nxt.rdata = {4'd0, st_r.refsel};
        drs_pkg::OFS_FMASK:  st_nxt.rdata = st_r.fmask;
        drs_pkg::OFS_WTR:    st_nxt.rdata = {4'd0, st_r.wtr};
        drs_pkg::OFS_REV:    st_nxt.rdata = st_r.rev;
        drs_pkg::OFS_STATUS: begin
          st_nxt.rdata = {5'd0, cur_fail_flag,
                          loop_locked && st_r.lstate == drs_pkg::LS_TRACK,
                          st_r.hold_flag};
        end
        default: begin
          if (is_rank(reg_addr)) begin
            st_nxt.rdata = {st_r.rank[rank_slot(reg_addr) + 3'd1],
                            st_r.rank[rank_slot(reg_addr)]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r            <= '0;
      st_r.inhibit    <= {drs_pkg::RST_INH, drs_pkg::RST_INH};
      st_r.timing     <= drs_pkg::RST_TIMING;
      st_r.ctl_a      <= drs_pkg::RST_CTL_A;
      st_r.ctl_b      <= drs_pkg::RST_CTL_B;
      // free-run until the mode straps are caught
      st_r.mode       <= drs_pkg::MD_FREE;
      st_r.refsel     <= drs_pkg::RST_ZERO[3:0];
      st_r.fmask      <= drs_pkg::RST_FMASK;
      st_r.rev        <= drs_pkg::RST_ZERO;
      st_r.rank       <= drs_pkg::RST_RANK;
      st_r.lstate     <= drs_pkg::LS_FREE;
      st_r.out.state  <= drs_pkg::LS_FREE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign loop_out  = st_r.out;
endmodule : drs_loop_ctrl
`default_nettype wire

// >>> verif/drs_ref_src.sv
// model of the eight monitored reference inputs
`timescale 1ns/100ps
`default_nettype none
module drs_ref_src (
  input  wire logic      clk,
  output var logic [7:0] mon_cycle_fail,
  output var logic [7:0] mon_coarse_fail,
  output var logic [7:0] mon_precise_fail,
  output var logic [7:0] ref_is_2k,
  output var logic [7:0] ref_is_8k,
  output var logic       loop_locked
);
  initial begin
    mon_cycle_fail   = 8'h00;
    mon_coarse_fail  = 8'h00;
    mon_precise_fail = 8'h00;
    ref_is_2k    = 8'h00;
    ref_is_8k    = 8'h00;
    loop_locked  = 1'b0;
  end
  // monitor levels change just after an edge, like real monitors
  task automatic put(input logic [7:0] c, p, k2, k8, input logic lk);
    @(posedge clk);
    mon_cycle_fail   <= c;
    mon_coarse_fail  <= c;
    mon_precise_fail <= p;
    ref_is_2k    <= k2;
    ref_is_8k    <= k8;
    loop_locked  <= lk;
  endtask : put
endmodule : drs_ref_src
`default_nettype wire

// >>> verif/drs_loop_props.sv
// checker: register bus and loop output relations
`timescale 1ns/100ps
`default_nettype none
module drs_loop_props (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire drs_pkg::drs_loop_out_t loop_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence mode_wr(logic [1:0] m);
    wr_at(drs_pkg::OFS_MODE) ##0 reg_wdata[1:0] == m;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    !($past(reg_addr) inside {[8'h1a:8'h28]}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_rsvd: assert property ($past(reg_rd) &&
    $past(reg_addr) == drs_pkg::OFS_STATUS |-> reg_rdata[7:3] == 5'h00)
    else $error("status reserved bits set");
  a_evt_track: assert property (loop_out.switch_evt |->
    loop_out.state == drs_pkg::LS_TRACK) else $error("switch event off track");
  a_hold_mode: assert property (mode_wr(drs_pkg::MD_HOLD) |->
    ##2 loop_out.state == drs_pkg::LS_HOLD) else $error("no holdover");
  a_free_mode: assert property (mode_wr(drs_pkg::MD_FREE) |->
    ##2 loop_out.state == drs_pkg::LS_FREE) else $error("no free-run");
  a_slew_apply: assert property (wr_at(drs_pkg::OFS_CTL_A) |-> ##2
    loop_out.slew_code == $past(reg_wdata[5:4], 2) &&
    loop_out.realign == $past(reg_wdata[0], 2)) else $error("ctl a not applied");
  a_offset_apply: assert property (wr_at(drs_pkg::OFS_CTL_B) |-> ##2
    loop_out.offset_en == $past(reg_wdata[1], 2)) else $error("offset bit lost");
endmodule : drs_loop_props
bind drs_loop_ctrl drs_loop_props drs_loop_props_inst (.*);
`default_nettype wire

// >>> verif/tb_drs_loop_ctrl.sv
// testbench: register map, mode control and reference choice
`timescale 1ns/100ps
`default_nettype none
module tb_drs_loop_ctrl;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [7:0]             reg_addr = 8'h00;
  logic [7:0]             reg_wdata = 8'h00;
  logic [7:0]             reg_rdata;
  logic [7:0]             cyf, crf, prf, k2, k8;
  logic                   lock;
  drs_pkg::drs_loop_out_t lo;
  int                     bad_count = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  // small tick and minute keep the run short
  drs_loop_ctrl #(.TICK_CYC(4), .MINUTE_TICK(3)) drs_loop_ctrl_inst (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hitless_strap(1'b1), .mode_strap(2'b10), .mon_cycle_fail(cyf),
    .mon_coarse_fail(crf), .mon_precise_fail(prf), .ref_is_2k(k2),
    .ref_is_8k(k8), .loop_locked(lock), .loop_out(lo));
  drs_ref_src drs_ref_src_inst (.clk(clk), .mon_cycle_fail(cyf),
    .mon_coarse_fail(crf), .mon_precise_fail(prf), .ref_is_2k(k2),
    .ref_is_8k(k8), .loop_locked(lock));
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask : rd
  // index bit 3 set means the index is not judged
  task automatic see(input drs_pkg::drs_lstate_t st, input logic [3:0] ix);
    repeat (6) @(posedge clk);
    #1 chk("loop state", {6'h00, st}, {6'h00, lo.state});
    if (!ix[3]) chk("ref index", {5'h00, ix[2:0]}, {5'h00, lo.ref_idx});
  endtask : see
  task automatic t_reset();
    logic [7:0] tbl [14] = '{8'hff, 8'hff, 8'h15, 8'h7a, 8'hc4, 8'h02, 8'h00,
                             8'h3c, 8'h00, 8'h00, 8'h10, 8'h32, 8'h54, 8'h76};
    for (int i = 0; i < 14; i++) begin
      rd(8'h1a + 8'(i), tbl[i], "reset value");
    end
    rd(8'h30, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_auto();
    wr(drs_pkg::OFS_MODE, 8'h03);
    see(drs_pkg::LS_TRACK, 4'd0);
    drs_ref_src_inst.put(8'h00, 8'h01, 8'h00, 8'h00, 1'b0);
    see(drs_pkg::LS_TRACK, 4'd1);
    wr(drs_pkg::OFS_REFSEL, 8'h06);
    rd(drs_pkg::OFS_REFSEL, 8'h01, "refsel in auto");
    drs_ref_src_inst.put(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    see(drs_pkg::LS_TRACK, 4'd1);
    wr(drs_pkg::OFS_CTL_B, 8'hc5);
    see(drs_pkg::LS_TRACK, 4'd1);
    wr(drs_pkg::OFS_REV, 8'h01);
    see(drs_pkg::LS_TRACK, 4'd0);
    wr(8'h25, 8'h22);
    drs_ref_src_inst.put(8'h00, 8'h03, 8'h00, 8'h00, 1'b0);
    see(drs_pkg::LS_TRACK, 4'd2);
    wr(8'h26, 8'h0f);
    drs_ref_src_inst.put(8'h00, 8'hef, 8'h00, 8'h00, 1'b0);
    see(drs_pkg::LS_HOLD, 4'h8);
  endtask : t_auto
  task automatic t_manual();
    logic [2:0]       bwc [4] = '{3'b011, 3'b100, 3'b101, 3'b110};
    drs_pkg::drs_bw_t bwe [4] = '{drs_pkg::BWE_14, drs_pkg::BWE_28,
                                  drs_pkg::BWE_890, drs_pkg::BWE_14};
    drs_ref_src_inst.put(8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    wr(drs_pkg::OFS_MODE, 8'h00);
    wr(drs_pkg::OFS_REFSEL, 8'h03);
    see(drs_pkg::LS_TRACK, 4'd3);
    rd(drs_pkg::OFS_STATUS, 8'h02, "status locked");
    for (int i = 0; i < 4; i++) begin
      wr(drs_pkg::OFS_CTL_A, {2'b01, 2'(i), bwc[i], i[0]});
      see(drs_pkg::LS_TRACK, 4'd3);
      chk("bandwidth", {6'h00, bwe[i]}, {6'h00, lo.bandwidth});
      chk("slew", 8'(i), {6'h00, lo.slew_code});
      chk("realign", {7'h00, i[0]}, {7'h00, lo.realign});
    end
    drs_ref_src_inst.put(8'h00, 8'h00, 8'h00, 8'h08, 1'b1);
    wr(drs_pkg::OFS_CTL_A, 8'h0a);
    see(drs_pkg::LS_TRACK, 4'd3);
    chk("bandwidth 8k", {6'h00, drs_pkg::BWE_56}, {6'h00, lo.bandwidth});
    drs_ref_src_inst.put(8'h00, 8'h00, 8'h08, 8'h00, 1'b1);
    wr(drs_pkg::OFS_CTL_B, 8'hc2);
    see(drs_pkg::LS_TRACK, 4'd3);
    chk("bandwidth 2k", {6'h00, drs_pkg::BWE_14}, {6'h00, lo.bandwidth});
    chk("offset enable", 8'h01, {7'h00, lo.offset_en});
    drs_ref_src_inst.put(8'h08, 8'h00, 8'h00, 8'h00, 1'b1);
    see(drs_pkg::LS_HOLD, 4'h8);
    rd(drs_pkg::OFS_STATUS, 8'h05, "status failed");
    drs_ref_src_inst.put(8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    wr(drs_pkg::OFS_MODE, 8'h01);
    see(drs_pkg::LS_HOLD, 4'h8);
    wr(drs_pkg::OFS_MODE, 8'h02);
    see(drs_pkg::LS_FREE, 4'h8);
  endtask : t_manual
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_auto();
    t_manual();
    tally_and_finish();
  end
endmodule : tb_drs_loop_ctrl
`default_nettype wire
